// ==== hdl/nbcrp_pkg.sv ====
package nbcrp_pkg;

    // ----------------------------------------------------------------
    // Bus and page geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int RW_WORDS = 12;
    localparam int RW_IDX_W = 4;

    localparam logic [ADDR_W-1:0] OFS_ID = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_RESET = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_QBASE_LO = 12'h010;
    localparam logic [ADDR_W-1:0] OFS_QBASE_HI = 12'h014;
    localparam logic [ADDR_W-1:0] OFS_RD_OFFSET = 12'h018;
    localparam logic [ADDR_W-1:0] OFS_QBUS = 12'h01c;
    localparam logic [ADDR_W-1:0] OFS_QLEN = 12'h020;
    localparam logic [ADDR_W-1:0] OFS_MASTER_PROTECTION_LEVEL = 12'h024;
    localparam logic [ADDR_W-1:0] OFS_BUILD = 12'h028;
    localparam logic [ADDR_W-1:0] OFS_LOCK = 12'h02c;
    localparam logic [ADDR_W-1:0] OFS_REGION = 12'h03c;
    localparam logic [ADDR_W-1:0] OFS_LIMIT0 = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_LIMIT1 = 12'h044;
    localparam logic [ADDR_W-1:0] OFS_LIMIT2 = 12'h048;
    localparam logic [ADDR_W-1:0] OFS_LIMIT3 = 12'h04c;

    // ----------------------------------------------------------------
    // Slots of the writable words in the word store
    // ----------------------------------------------------------------
    localparam logic [RW_IDX_W-1:0] IDX_CMD = 4'h0;
    localparam logic [RW_IDX_W-1:0] IDX_RESET = 4'h1;
    localparam logic [RW_IDX_W-1:0] IDX_QBASE_LO = 4'h2;
    localparam logic [RW_IDX_W-1:0] IDX_QBASE_HI = 4'h3;
    localparam logic [RW_IDX_W-1:0] IDX_QBUS = 4'h4;
    localparam logic [RW_IDX_W-1:0] IDX_QLEN = 4'h5;
    localparam logic [RW_IDX_W-1:0] IDX_LOCK = 4'h6;
    localparam logic [RW_IDX_W-1:0] IDX_REGION = 4'h7;
    localparam logic [RW_IDX_W-1:0] IDX_LIMIT0 = 4'h8;
    localparam logic [RW_IDX_W-1:0] IDX_LIMIT1 = 4'h9;
    localparam logic [RW_IDX_W-1:0] IDX_LIMIT2 = 4'ha;
    localparam logic [RW_IDX_W-1:0] IDX_LIMIT3 = 4'hb;

    // ----------------------------------------------------------------
    // Reset values, fields and masks
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] CMD_RESET = 32'h0000000c;
    localparam logic [DATA_W-1:0] BUILD_256 = 32'h10003008;
    localparam logic [DATA_W-1:0] BUILD_512 = 32'h10006009;
    localparam logic [DATA_W-1:0] QBASE_LO_MASK = 32'hfffffffc;
    localparam logic [DATA_W-1:0] QBASE_HI_MASK = 32'h000000ff;
    localparam logic [DATA_W-1:0] QBUS_MASK = 32'h00000003;
    localparam logic [DATA_W-1:0] QLEN_MASK = 32'h01fffffc;
    localparam logic [DATA_W-1:0] RD_OFFSET_MASK = 32'h00fffffc;
    localparam int RESET_BUSY_BIT = 3;
    localparam int PRIV_BIT = 0;
    localparam int NSEC_BIT = 1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 50;
    localparam int RESET_HOLD_NS = 40;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * CLK_FREQ_MHZ + 999) / 1000;

    typedef enum logic [1:0] {ST_HOLD, ST_CLEAR, ST_RUN, ST_DRAIN} nbcrp_state_t;

endpackage : nbcrp_pkg

// ==== hdl/nbcrp_mem_if.sv ====
`timescale 1ns/1ps
interface nbcrp_mem_if #(
    parameter int WIDTH = 32,
    parameter int AW = 4
);
    logic we;
    logic [AW-1:0] waddr;
    logic [WIDTH-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [WIDTH-1:0] rdata;

    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : nbcrp_mem_if

// ==== hdl/nbcrp_word_ram.sv ====
`timescale 1ns/1ps
module nbcrp_word_ram #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 12
) (
    input wire logic clk_i,
    nbcrp_mem_if.store mem
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] words;
        logic [WIDTH-1:0] rdata;
    } nbcrp_ram_t;

    nbcrp_ram_t s_q;
    nbcrp_ram_t s_d;

    // No reset here: the owner rewrites every word after each reset
    always_comb begin
        s_d = s_q;
        if (mem.we && (int'(mem.waddr) < DEPTH)) begin
            s_d.words[mem.waddr] = mem.wdata;
        end
        if (int'(mem.raddr) < DEPTH) begin
            s_d.rdata = s_q.words[mem.raddr];
        end else begin
            s_d.rdata = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign mem.rdata = s_q.rdata;

endmodule : nbcrp_word_ram

// ==== hdl/nbcrp_top.sv ====
`timescale 1ns/1ps
module nbcrp_top
    import nbcrp_pkg::*;
#(
    parameter logic [DATA_W-1:0] ID_VALUE = 32'h00a50001, // Arbitrary value
    parameter bit BUILD_IS_512 = 1'b0
) (
    input wire logic CLK_I,
    input wire logic SRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [DATA_W-1:0] PWDATA_I,
    input wire logic [2:0] PPROT_I,
    output logic [DATA_W-1:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [DATA_W-1:0] UNIT_STATUS_I,
    input wire logic [DATA_W-1:0] QUEUE_READ_OFFSET_I,
    input wire logic SOFT_RESET_ACK_I,
    output logic SOFT_RESET_REQ_O,
    output logic UNIT_RESET_O,
    output logic [1:0] MASTER_MASTER_PROTECTION_LEVEL_O,
    output logic WR_STROBE_O,
    output logic [RW_IDX_W-1:0] WR_INDEX_O,
    output logic [DATA_W-1:0] WR_DATA_O
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        nbcrp_state_t st;
        logic [RW_IDX_W-1:0] cnt;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic [1:0] master_protection_level;
        logic [1:0] pend;
        logic wr_stb;
        logic [RW_IDX_W-1:0] wr_idx;
        logic [DATA_W-1:0] wr_dat;
    } nbcrp_regs_t;

    localparam logic [RW_IDX_W-1:0] HOLD_LAST = RW_IDX_W'(RESET_HOLD_CYC - 1);
    localparam logic [RW_IDX_W-1:0] CLEAR_LAST = RW_IDX_W'(RW_WORDS - 1);
    localparam logic [DATA_W-1:0] BUILD_WORD = BUILD_IS_512 ? BUILD_512 : BUILD_256;

    nbcrp_regs_t s_q;
    nbcrp_regs_t s_d;

    // ----------------------------------------------------------------
    // Decoding
    // ----------------------------------------------------------------
    // Writable words live in the word store; returns {hit, slot}
    function automatic logic [RW_IDX_W:0] rw_slot(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_CMD: rw_slot = {1'b1, IDX_CMD};
            OFS_RESET: rw_slot = {1'b1, IDX_RESET};
            OFS_QBASE_LO: rw_slot = {1'b1, IDX_QBASE_LO};
            OFS_QBASE_HI: rw_slot = {1'b1, IDX_QBASE_HI};
            OFS_QBUS: rw_slot = {1'b1, IDX_QBUS};
            OFS_QLEN: rw_slot = {1'b1, IDX_QLEN};
            OFS_LOCK: rw_slot = {1'b1, IDX_LOCK};
            OFS_REGION: rw_slot = {1'b1, IDX_REGION};
            OFS_LIMIT0: rw_slot = {1'b1, IDX_LIMIT0};
            OFS_LIMIT1: rw_slot = {1'b1, IDX_LIMIT1};
            OFS_LIMIT2: rw_slot = {1'b1, IDX_LIMIT2};
            OFS_LIMIT3: rw_slot = {1'b1, IDX_LIMIT3};
            default: rw_slot = '0;
        endcase
    endfunction : rw_slot

    // Bits that a word can hold; the rest are dropped on write
    function automatic logic [DATA_W-1:0] wr_mask(input logic [RW_IDX_W-1:0] i);
        case (i)
            IDX_QBASE_LO: wr_mask = QBASE_LO_MASK;
            IDX_QBASE_HI: wr_mask = QBASE_HI_MASK;
            IDX_QBUS: wr_mask = QBUS_MASK;
            IDX_QLEN: wr_mask = QLEN_MASK;
            default: wr_mask = 32'hffffffff;
        endcase
    endfunction : wr_mask

    function automatic logic [DATA_W-1:0] rw_reset(input logic [RW_IDX_W-1:0] i);
        if (i == IDX_CMD) begin
            rw_reset = CMD_RESET;
        end else begin
            rw_reset = '0;
        end
    endfunction : rw_reset

    // ----------------------------------------------------------------
    // Access checks
    // ----------------------------------------------------------------
    logic acc;
    logic permitted;
    logic busy;
    logic [RW_IDX_W:0] slot;
    logic slot_hit;
    logic [RW_IDX_W-1:0] slot_idx;
    logic wr_ok;
    logic clearing;
    logic ro_hit;
    logic [DATA_W-1:0] status_word;
    logic [DATA_W-1:0] rd_val;

    // First access cycle; the second one completes the transfer
    assign acc = PSEL_I && PENABLE_I && !s_q.ack;
    assign permitted = (PPROT_I[PRIV_BIT] >= s_q.master_protection_level[PRIV_BIT]) &&
        (PPROT_I[NSEC_BIT] <= s_q.master_protection_level[NSEC_BIT]);
    assign busy = (s_q.st != ST_RUN);
    assign clearing = (s_q.st == ST_CLEAR);
    assign slot = rw_slot(PADDR_I);
    assign slot_hit = slot[RW_IDX_W];
    assign slot_idx = slot[RW_IDX_W-1:0];
    // Strobes are not looked at: host writes whole words only
    assign wr_ok = acc && PWRITE_I && permitted && !busy && slot_hit;
    assign ro_hit = (PADDR_I == OFS_ID) || (PADDR_I == OFS_STATUS) ||
        (PADDR_I == OFS_RD_OFFSET) || (PADDR_I == OFS_MASTER_PROTECTION_LEVEL) || (PADDR_I == OFS_BUILD);

    always_comb begin
        status_word = UNIT_STATUS_I;
        status_word[RESET_BUSY_BIT] = busy;
    end

    // ----------------------------------------------------------------
    // Word store
    // ----------------------------------------------------------------
    nbcrp_mem_if #(.WIDTH(DATA_W), .AW(RW_IDX_W)) mem_bus ();

    // Reset rewrites the writable words with their reset values one per cycle
    assign mem_bus.we = clearing || wr_ok;
    assign mem_bus.waddr = clearing ? s_q.cnt : slot_idx;
    assign mem_bus.wdata = clearing ? rw_reset(s_q.cnt) : (PWDATA_I & wr_mask(slot_idx));
    assign mem_bus.raddr = slot_idx;

    nbcrp_word_ram #(.WIDTH(DATA_W), .DEPTH(RW_WORDS)) u_store (
        .clk_i(CLK_I),
        .mem(mem_bus)
    );

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always_comb begin
        rd_val = '0;
        if (busy) begin
            if (PADDR_I == OFS_STATUS) begin
                rd_val = status_word;
            end
        end else if (permitted) begin
            case (PADDR_I)
                OFS_ID: rd_val = ID_VALUE;
                OFS_STATUS: rd_val = status_word;
                OFS_RD_OFFSET: rd_val = QUEUE_READ_OFFSET_I & RD_OFFSET_MASK;
                OFS_MASTER_PROTECTION_LEVEL: rd_val = {30'h0, s_q.master_protection_level};
                OFS_BUILD: rd_val = BUILD_WORD;
                default: rd_val = slot_hit ? mem_bus.rdata : '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = PSEL_I && PENABLE_I && !s_q.ack;
        s_d.wr_stb = 1'b0;
        if (acc && !PWRITE_I) begin
            s_d.rdata = rd_val;
        end
        if (wr_ok) begin
            s_d.wr_stb = 1'b1;
            s_d.wr_idx = slot_idx;
            s_d.wr_dat = PWDATA_I & wr_mask(slot_idx);
        end
        case (s_q.st)
            ST_RUN: begin
                if (wr_ok && (slot_idx == IDX_RESET)) begin
                    s_d.pend = PWDATA_I[1:0];
                    s_d.st = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                // Unit must finish bus traffic before its reset
                if (SOFT_RESET_ACK_I) begin
                    s_d.st = ST_HOLD;
                    s_d.cnt = '0;
                end
            end
            ST_HOLD: begin
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == HOLD_LAST) begin
                    s_d.st = ST_CLEAR;
                    s_d.cnt = '0;
                end
            end
            ST_CLEAR: begin
                s_d.cnt = s_q.cnt + 4'h1;
                if (s_q.cnt == CLEAR_LAST) begin
                    s_d.st = ST_RUN;
                    s_d.cnt = '0;
                    s_d.master_protection_level = s_q.pend;
                    s_d.pend = '0;
                end
            end
            default: begin
                s_d.st = ST_HOLD;
                s_d.cnt = '0;
            end
        endcase
        if (SRST_I) begin
            s_d = '0;
            s_d.st = ST_HOLD;
        end
    end

    always_ff @(posedge CLK_I) begin
        s_q <= s_d;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PREADY_O = PSEL_I && PENABLE_I && s_q.ack;
    // Refusals are silent, never an error response
    assign PSLVERR_O = 1'b0;
    assign PRDATA_O = s_q.rdata;
    assign SOFT_RESET_REQ_O = (s_q.st == ST_DRAIN);
    assign UNIT_RESET_O = (s_q.st == ST_HOLD);
    assign MASTER_MASTER_PROTECTION_LEVEL_O = s_q.master_protection_level;
    assign WR_STROBE_O = s_q.wr_stb;
    assign WR_INDEX_O = s_q.wr_idx;
    assign WR_DATA_O = s_q.wr_dat;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);

    chk_denied_read_zero: assert property (
        (PREADY_O && !PWRITE_I && $past(!permitted && !busy)) |-> (PRDATA_O == '0)
    ) else $error("Refused read returned nonzero data");

    chk_busy_read_zero: assert property (
        (PREADY_O && !PWRITE_I && $past(busy) && (PADDR_I != OFS_STATUS))
        |-> (PRDATA_O == '0)
    ) else $error("Register other than status readable during reset");

    chk_busy_status_bit: assert property (
        (PREADY_O && !PWRITE_I && $past(busy) && (PADDR_I == OFS_STATUS))
        |-> PRDATA_O[RESET_BUSY_BIT]
    ) else $error("Status read during reset lacks busy bit");

    chk_write_gate: assert property (
        (acc && PWRITE_I && (!permitted || busy || ro_hit)) |-> ((clearing || !mem_bus.we) ##1 !WR_STROBE_O)
    ) else $error("Refused or read-only write reached the word store");

    chk_soft_reset_start: assert property (
        (wr_ok && (slot_idx == IDX_RESET) && !busy)
        |=> (SOFT_RESET_REQ_O && !UNIT_RESET_O)
    ) else $error("Permitted reset write did not start soft reset");

    chk_denied_no_reset: assert property (
        (acc && PWRITE_I && !permitted && !busy && (PADDR_I == OFS_RESET))
        |=> !busy
    ) else $error("Refused reset write started a reset");

    chk_master_protection_level_update: assert property (
        (clearing && (s_q.cnt == CLEAR_LAST))
        |=> ((MASTER_MASTER_PROTECTION_LEVEL_O == $past(s_q.pend)) && !busy)
    ) else $error("Protection level not taken at end of reset");

    chk_hard_reset_seq: assert property (
        $fell(SRST_I) |-> (UNIT_RESET_O && (s_q.cnt == '0)) ##2 clearing ##12 !busy
    ) else $error("Reset sequence length wrong");

    chk_unmapped_zero: assert property (
        (PREADY_O && !PWRITE_I && !slot_hit && !ro_hit) |-> (PRDATA_O == '0)
    ) else $error("Unmapped offset read nonzero");

    chk_build_word: assert property (
        (PREADY_O && !PWRITE_I && $past(permitted && !busy) && (PADDR_I == OFS_BUILD))
        |-> (PRDATA_O == BUILD_WORD)
    ) else $error("Build word read wrong");

    chk_qbase_aligned: assert property (
        (wr_ok && (slot_idx == IDX_QBASE_LO)) |=> (WR_STROBE_O && (WR_DATA_O[1:0] == 2'h0))
    ) else $error("Queue base low word stored unaligned");

    chk_qbase_high_bits: assert property (
        (wr_ok && (slot_idx == IDX_QBASE_HI)) |=> (WR_DATA_O[31:8] == 24'h000000)
    ) else $error("Queue base high word holds bits above 39");

    chk_qbus_range: assert property (
        (wr_ok && (slot_idx == IDX_QBUS)) |=> (WR_DATA_O[31:2] == 30'h00000000)
    ) else $error("Queue bus setting outside 0 to 3");

    chk_qlen_multiple: assert property (
        (wr_ok && (slot_idx == IDX_QLEN)) |=> (WR_DATA_O[1:0] == 2'h0)
    ) else $error("Queue length not a multiple of four");

    chk_offset_aligned: assert property (
        (PREADY_O && !PWRITE_I && $past(permitted && !busy) && (PADDR_I == OFS_RD_OFFSET))
        |-> ((PRDATA_O[1:0] == 2'h0) && (PRDATA_O[31:24] == 8'h00))
    ) else $error("Read offset not a word offset within range");

    chk_master_protection_level_read_only: assert property (
        (acc && PWRITE_I && !busy && (PADDR_I == OFS_MASTER_PROTECTION_LEVEL)) |=> $stable(MASTER_MASTER_PROTECTION_LEVEL_O)
    ) else $error("Write changed the protection level");

    // Unit reset pulse must cover the two hold cycles exactly
    chk_unit_reset_len: assert property (
        $rose(UNIT_RESET_O) |=> UNIT_RESET_O ##1 !UNIT_RESET_O
    ) else $error("Unit reset not held for two cycles");

endmodule : nbcrp_top

// ==== test/nbcrp_host_model.sv ====
`timescale 1ns/1ps
module nbcrp_host_model
    import nbcrp_pkg::*;
(
    input wire logic clk_i,
    input wire logic pready_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [ADDR_W-1:0] paddr_o,
    output logic [DATA_W-1:0] pwdata_o,
    output logic [2:0] pprot_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = '0;
        pwdata_o = '0;
        pprot_o = 3'h0;
    end

    // ----------------------------------------------------------------
    // One word transfer; held until ready is sampled at a rising edge, for at most eight edges
    // ----------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d, input logic [2:0] p,
                        output logic done);
        @(negedge clk_i);
        psel_o = 1'b1;
        penable_o = 1'b0;
        pwrite_o = wr;
        paddr_o = a;
        pwdata_o = d;
        pprot_o = p;
        @(negedge clk_i);
        penable_o = 1'b1;
        done = 1'b0;
        for (int i = 0; i < 8 && !done; i++) begin
            @(posedge clk_i);
            done = (pready_i === 1'b1);
        end
        @(negedge clk_i);
        psel_o = 1'b0;
        penable_o = 1'b0;
        // Released lines must not look like a held value
        paddr_o = ~paddr_o;
        pwdata_o = ~pwdata_o;
    endtask : xfer
endmodule : nbcrp_host_model

// ==== test/nbcrp_top_bench.sv ====
`timescale 1ns/1ps
module nbcrp_top_bench
    import nbcrp_pkg::*;
;
    localparam logic [DATA_W-1:0] ID_CODE = 32'h00c30a17; // Arbitrary value
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, soft_req, unit_rst, wr_stb;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, wr_data, d;
    logic [2:0] pprot;
    logic [1:0] mprot;
    logic [RW_IDX_W-1:0] wr_idx;
    logic [DATA_W-1:0] ustat = '0;
    logic [DATA_W-1:0] qofs = '0;
    logic soft_ack = 1'b0;
    logic [36:0] notes[$];
    logic [36:0] n;
    logic [DATA_W-1:0] shadow [11];
    int bad_count = 0;
    int compares = 0;
    logic [ADDR_W-1:0] rw_ofs [11] = '{OFS_CMD, OFS_QBASE_LO, OFS_QBASE_HI, OFS_QBUS, OFS_QLEN,
        OFS_LOCK, OFS_REGION, OFS_LIMIT0, OFS_LIMIT1, OFS_LIMIT2, OFS_LIMIT3};
    logic [RW_IDX_W-1:0] rw_idx [11] = '{IDX_CMD, IDX_QBASE_LO, IDX_QBASE_HI, IDX_QBUS, IDX_QLEN,
        IDX_LOCK, IDX_REGION, IDX_LIMIT0, IDX_LIMIT1, IDX_LIMIT2, IDX_LIMIT3};
    logic [DATA_W-1:0] rw_msk [11] = '{32'hffffffff, QBASE_LO_MASK, QBASE_HI_MASK, QBUS_MASK,
        QLEN_MASK, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hffffffff};
    logic [ADDR_W-1:0] ro_ofs [7] = '{OFS_ID, OFS_STATUS, OFS_RD_OFFSET, OFS_MASTER_PROTECTION_LEVEL, OFS_BUILD,
        12'h030, 12'h041};

    always #10 clk = ~clk;

    // Unit side acknowledges a soft reset request half a cycle late
    always @(negedge clk) soft_ack <= soft_req;

    nbcrp_top #(.ID_VALUE(ID_CODE), .BUILD_IS_512(1'b0)) u_dut (
        .CLK_I(clk), .SRST_I(srst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PPROT_I(pprot), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .UNIT_STATUS_I(ustat),
        .QUEUE_READ_OFFSET_I(qofs), .SOFT_RESET_ACK_I(soft_ack), .SOFT_RESET_REQ_O(soft_req),
        .UNIT_RESET_O(unit_rst), .MASTER_MASTER_PROTECTION_LEVEL_O(mprot), .WR_STROBE_O(wr_stb),
        .WR_INDEX_O(wr_idx), .WR_DATA_O(wr_data));

    nbcrp_host_model u_host (.clk_i(clk), .pready_i(pready), .psel_o(psel),
        .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .pprot_o(pprot));

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic summarize;
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dd,
                       input logic [2:0] p, input logic [36:0] note);
        logic done;
        notes.push_back(note);
        u_host.xfer(wr, a, dd, p, done);
        if (!done) begin
            bad_count++;
            summarize();
        end
    endtask : acc

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
                      input logic [2:0] p);
        acc(1'b0, a, 32'h0, p, {5'h0, e});
    endtask : rd

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dd,
                      input logic [2:0] p, input logic stb, input logic [3:0] ix,
                      input logic [DATA_W-1:0] e);
        acc(1'b1, a, dd, p, {stb, ix, e});
    endtask : wr

    function automatic logic [DATA_W-1:0] rv(input logic [ADDR_W-1:0] a);
        case (a)
            OFS_ID: rv = ID_CODE;
            OFS_STATUS: rv = ustat & 32'hfffffff7;
            OFS_CMD: rv = CMD_RESET;
            OFS_RD_OFFSET: rv = qofs & RD_OFFSET_MASK;
            OFS_BUILD: rv = BUILD_256;
            default: rv = 32'h0;
        endcase
    endfunction : rv

    // Results are paired with notes at the edge where ready is sampled
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1) begin
            chk({36'h0, pslverr}, 37'h0);
            if (notes.size() == 0) begin
                chk(37'h0, 37'h1);
            end else begin
                n = notes.pop_front();
                if (pwrite && n[36]) begin
                    chk({wr_stb, wr_idx, wr_data}, n);
                end else if (pwrite) begin
                    chk({wr_stb, 36'h0}, n);
                end else begin
                    chk({5'h0, prdata}, n);
                end
            end
        end
    end

    initial begin
        repeat (4000) @(posedge clk);
        bad_count++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32395));
        ustat = $urandom;
        qofs = $urandom;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        rd(OFS_STATUS, ustat | 32'h8, 3'h0);
        rd(OFS_CMD, 32'h0, 3'h0);
        wr(OFS_LOCK, 32'h5a, 3'h0, 1'b0, 4'h0, 32'h0);
        repeat (12) @(negedge clk);
        for (int i = 0; i < 20; i++) begin
            rd(ADDR_W'(4 * i), rv(ADDR_W'(4 * i)), 3'h0);
        end
        for (int i = 0; i < 11; i++) begin
            d = $urandom;
            shadow[i] = d & rw_msk[i];
            wr(rw_ofs[i], d, 3'h0, 1'b1, rw_idx[i], shadow[i]);
            rd(rw_ofs[i], shadow[i], 3'h0);
        end
        for (int i = 0; i < 7; i++) begin
            wr(ro_ofs[i], $urandom, 3'h4, 1'b0, 4'h0, 32'h0);
            rd(ro_ofs[i], rv(ro_ofs[i]), 3'h1);
        end
        wr(OFS_LOCK, ~shadow[5], 3'h2, 1'b0, 4'h0, 32'h0);
        rd(OFS_LOCK, 32'h0, 3'h3);
        rd(OFS_LOCK, shadow[5], 3'h1);
        wr(OFS_RESET, 32'h3, 3'h0, 1'b1, IDX_RESET, 32'h3);
        for (int i = 0; i < 20 && unit_rst !== 1'b1; i++) @(negedge clk);
        chk({36'h0, unit_rst}, 37'h1);
        rd(OFS_STATUS, ustat | 32'h8, 3'h0);
        repeat (20) @(negedge clk);
        chk(37'(mprot), 37'h3);
        rd(OFS_CMD, 32'h0, 3'h0);
        rd(OFS_CMD, CMD_RESET, 3'h3);
        rd(OFS_LIMIT3, 32'h0, 3'h1);
        rd(OFS_RESET, 32'h0, 3'h1);
        wr(OFS_RESET, 32'h0, 3'h2, 1'b0, 4'h0, 32'h0);
        repeat (4) @(negedge clk);
        chk({36'h0, soft_req}, 37'h0);
        summarize();
    end
endmodule : nbcrp_top_bench
